// >>> logic/uppc_pkg.sv
// Purpose: Constants for the USB/PS2 port control register bank
// Assumes: AHB-Lite slave, 32-bit data, one register per aligned word
// Notes:   Printed offsets are not word aligned, so byte address is index times four
//
// Behaviour
// R1: Port C bits 0-3 general I/O, PWM on 2,3
// R2: Port C bit 5 selects pulse clock source
// R3: Port C bit 6 enables pulse output A
// R4: Port C bit 7 enables pulse output B
// R5: Direction register controls bits 0-3 only
// R6: Status bit 0 reads suspend state
// R7: Status bit 1 write-only wake request, reset 0
// R8: Status bit 2 bus reset flag, read/write
// R9: Status bit 3 read-only resume-out flag
// R10: Status bits 6,7 drive PS2 lines, reset 1
// R11: Mode bits 0,1 are endpoint event flags
// R12: Endpoint access sets flag, raises USB interrupt
// R13: Firmware clears flag before next event accepted
// R14: Software writes zero to mode bits 2,3
// R15: Mode bit 4 selects PS2 mode
// R16: Mode bit 5 selects USB mode
// R17: Mode bit 6 selects converter reference, reset 1
// R18: Mode bit 7 firmware USB marker
// R19: Clock bit 3 switches USB clock
// R20: Clock bit 4 enables second suspend pull-up
// R21: Clock bit 6 selects oscillator frequency
// R22: Clock bit 7 firmware PS2 marker
// R23: PS2 mode repurposes data pins as PS2
// R24: PS2 mode status bits 4,5 show lines
// R25: Firmware holds drive high before reading line
// R26: Enabled pulse output overrides direction bit
`default_nettype none
package uppc_pkg;
    // ----------------------------------------------------------------
    // Register indices and byte addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_PORTC   = 8'h16;   // Port C data and pulse control
    localparam logic [7:0] IDX_PORTC_D = 8'h17;   // Port C direction
    localparam logic [7:0] IDX_STAT    = 8'h1a;   // Serial link status and control
    localparam logic [7:0] IDX_MODE    = 8'h1b;   // Endpoint event and mode
    localparam logic [7:0] IDX_CLK     = 8'h1c;   // System clock control
    localparam int unsigned ADDR_W     = 10;      // Byte address bits decoded
    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int unsigned PC_PWM_A   = 2; // Pin carrying pulse output A
    localparam int unsigned PC_PWM_B   = 3; // Pin carrying pulse output B
    localparam int unsigned PC_SRC     = 5; // Pulse clock source select
    localparam int unsigned PC_EN_A    = 6; // Pulse output A enable
    localparam int unsigned PC_EN_B    = 7; // Pulse output B enable
    localparam int unsigned ST_SUSP    = 0; // Suspend status
    localparam int unsigned ST_WAKE    = 1; // Remote wake request
    localparam int unsigned ST_BRST    = 2; // Bus reset event
    localparam int unsigned ST_RES     = 3; // Resume-out event
    localparam int unsigned ST_DIN     = 4; // PS2 data line level
    localparam int unsigned ST_CIN     = 5; // PS2 clock line level
    localparam int unsigned ST_DDRV    = 6; // PS2 data drive
    localparam int unsigned ST_CDRV    = 7; // PS2 clock drive
    localparam int unsigned MD_EP0     = 0; // Endpoint zero event
    localparam int unsigned MD_EP1     = 1; // Endpoint one event
    localparam int unsigned MD_PS2     = 4; // PS2 mode select
    localparam int unsigned MD_USB     = 5; // USB mode select
    localparam int unsigned MD_VREF    = 6; // Converter reference select
    localparam int unsigned MD_MARK    = 7; // USB mode marker
    localparam int unsigned CK_USBEN   = 3; // USB clock enable
    localparam int unsigned CK_SUSP2   = 4; // Second suspend pull-up
    localparam int unsigned CK_FREQ    = 6; // Oscillator frequency select
    localparam int unsigned CK_MARK    = 7; // PS2 mode marker
    // ----------------------------------------------------------------
    // Reset values and write masks
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_PORTC   = 8'h00;   // Sources T1, both outputs off
    localparam logic [7:0] RST_DIR     = 8'h00;   // All pins input
    localparam logic [7:0] RST_DRV     = 8'hc0;   // Both PS2 drives high
    localparam logic [7:0] RST_MODE    = 8'h40;   // Internal reference
    localparam logic [7:0] RST_CLK     = 8'h00;   // 12 MHz, USB clock off
    localparam logic [7:0] MSK_PORTC   = 8'hef;   // Bit 4 reserved
    localparam logic [7:0] MSK_DIR     = 8'h0f;   // Upper pins have no direction
    localparam logic [7:0] MSK_MODE    = 8'hfc;   // Mode bits 2-7, above the endpoint flags
endpackage : uppc_pkg
`default_nettype wire

// >>> logic/uppc_regs.sv
// Purpose: USB/PS2 port control register bank behind an AHB-Lite slave
// Assumes: One clock, asynchronous active-high reset, word-only transfers
// Notes:   Always answers OKAY with zero wait states
`timescale 1ns/1ns
`default_nettype none
module uppc_regs #(
    parameter int unsigned PORT_W = 4             // Port C pins with direction control
) (
    input  wire logic              mclk_i,            // System clock
    input  wire logic              rst_i,             // Async reset, active high
    // AHB-Lite slave
    input  wire logic              hsel_i,            // Slave select
    input  wire logic [31:0]       haddr_i,           // Byte address
    input  wire logic [1:0]        htrans_i,          // Transfer type
    input  wire logic              hwrite_i,          // Write when high
    input  wire logic [2:0]        hsize_i,           // Transfer size
    input  wire logic [31:0]       hwdata_i,          // Write data
    input  wire logic              hready_i,          // Bus ready
    output logic [31:0]            hrdata_o,          // Read data
    output logic                   hreadyout_o,       // Slave ready
    output logic                   hresp_o,           // Response, always OKAY
    // Port C pins
    input  wire logic [PORT_W-1:0] port_c_in_i,       // Pin levels
    output logic [PORT_W-1:0]      port_c_out_o,      // Pin drive values
    output logic [PORT_W-1:0]      port_c_oe_o,       // Pin drive enables
    input  wire logic              pulse_out_a_i,     // Pulse generator A waveform
    input  wire logic              pulse_out_b_i,     // Pulse generator B waveform
    output logic                   pulse_src_sys_o,   // 1: system clock, 0: prescaled
    // Serial engine side
    input  wire logic              suspend_i,         // Link in suspend
    input  wire logic              bus_reset_i,       // Bus reset seen, pulse
    input  wire logic              resume_out_i,      // Resume-out event, pulse
    input  wire logic              ep0_access_i,      // Host hit endpoint zero, pulse
    input  wire logic              ep1_access_i,      // Host hit endpoint one, pulse
    input  wire logic              usb_int_en_i,      // USB interrupt enabled
    input  wire logic              stack_full_i,      // Call stack full
    output logic                   usb_irq_o,         // USB interrupt request, pulse
    output logic                   ep0_busy_o,        // Endpoint zero flag pending
    output logic                   ep1_busy_o,        // Endpoint one flag pending
    output logic                   remote_wake_request_o, // Wake pulse request
    // PS2 lines, open-drain on the USB data pins
    input  wire logic              kbd_data_in_i,     // Data pin level (minus line)
    input  wire logic              kbd_clock_in_i,    // Clock pin level (plus line)
    output logic                   kbd_data_oe_o,     // Pull data pin low
    output logic                   kbd_clock_oe_o,    // Pull clock pin low
    output logic                   kbd_mode_o,        // PS2 pin mode active
    // Configuration outputs
    output logic                   converter_reference_select_o, // 1: internal supply
    output logic                   usb_clock_enable_o,  // USB clock on
    output logic                   second_suspend_pullup_o, // Minus line pull-up
    output logic                   oscillator_freq_select_o // 1: 6 MHz, 0: 12 MHz
);
    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [7:0]        portc_q;           // Port C data and pulse control
    logic [PORT_W-1:0] dir_q;             // Direction, 1 = output
    logic [1:0]        drv_q;             // PS2 data/clock drives
    logic              wake_q;            // Remote wake request
    logic              brst_q;            // Bus reset flag
    logic              res_q;             // Resume-out flag
    logic [1:0]        ep_q;              // Endpoint event flags
    logic [7:0]        mode_q;            // Mode bits 4..7 held here
    logic [7:0]        clk_q;             // Clock control
    logic [1:0]        sync_a_q;          // PS2 pin sync stage one
    logic [1:0]        sync_b_q;          // PS2 pin sync stage two
    logic [PORT_W-1:0] pin_a_q;           // Port pin sync stage one
    logic [PORT_W-1:0] pin_b_q;           // Port pin sync stage two
    // Pending data phase
    logic              wr_ph_q;           // Write data phase pending
    logic [7:0]        wr_idx_q;          // Write register index
    // Address phase decode
    logic              valid_ph;          // Accepted transfer
    logic [7:0]        a_idx;             // Index of address phase
    logic [7:0]        wd;                // Write byte
    logic [7:0]        stat_rd;           // Status read image
    logic [7:0]        rd_d;              // Read byte

    localparam int unsigned ADDR_W_L = uppc_pkg::ADDR_W;
    assign valid_ph = hsel_i && hready_i && htrans_i[1];
    assign a_idx    = 8'(haddr_i[ADDR_W_L-1:2]);
    assign wd       = hwdata_i[7:0];

    // Write strobe for one register
    function automatic logic wsel(input logic [7:0] idx);
        wsel = wr_ph_q && (wr_idx_q == idx);
    endfunction : wsel

    // ----------------------------------------------------------------
    // Bus slave: phase tracking and read data
    // ----------------------------------------------------------------
    // Capture write address; reads return data in the data phase
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ph_q  <= 1'b0;
            wr_idx_q <= 8'h00;
        end else begin
            wr_ph_q  <= valid_ph && hwrite_i;
            wr_idx_q <= a_idx;
        end
    end

    // Status image: live PS2 levels gated by own drive, see R24, see R25
    always_comb begin
        stat_rd = 8'h00;
        stat_rd[uppc_pkg::ST_SUSP] = suspend_i; // see R6
        stat_rd[uppc_pkg::ST_BRST] = brst_q; // see R8
        stat_rd[uppc_pkg::ST_RES]  = res_q; // see R9
        stat_rd[uppc_pkg::ST_DIN]  = kbd_mode_o & sync_b_q[0] & drv_q[0]; // see R24
        stat_rd[uppc_pkg::ST_CIN]  = kbd_mode_o & sync_b_q[1] & drv_q[1]; // see R24
    end

    // Read multiplexer; unmapped reads give zero, write-only bits read zero
    always_comb begin
        case (a_idx)
            uppc_pkg::IDX_PORTC: begin
                rd_d = portc_q & uppc_pkg::MSK_PORTC;
                rd_d[PORT_W-1:0] = pin_b_q; // see R1
            end
            uppc_pkg::IDX_PORTC_D: rd_d = 8'(dir_q); // see R5
            uppc_pkg::IDX_STAT:    rd_d = stat_rd;
            uppc_pkg::IDX_MODE:    rd_d = mode_q | {6'h00, ep_q}; // see R11
            uppc_pkg::IDX_CLK:     rd_d = clk_q;
            default:               rd_d = 8'h00;
        endcase
    end

    // Read data registered for the data phase
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            hrdata_o <= 32'h0000_0000;
        end else if (valid_ph && !hwrite_i) begin
            hrdata_o <= {24'h000000, rd_d};
        end
    end

    // Zero wait states, OKAY only
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Port C data and direction
    // ----------------------------------------------------------------
    // Data, source select and enables; bit 4 reserved
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            portc_q <= uppc_pkg::RST_PORTC; // see R3, see R4
        end else if (wsel(uppc_pkg::IDX_PORTC)) begin
            portc_q <= wd & uppc_pkg::MSK_PORTC; // see R1, see R2
        end
    end

    // Direction only for the lower pins
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            dir_q <= PORT_W'(uppc_pkg::RST_DIR);
        end else if (wsel(uppc_pkg::IDX_PORTC_D)) begin
            dir_q <= PORT_W'(wd & uppc_pkg::MSK_DIR); // see R5
        end
    end

    // Pin drive: enabled pulse output overrides direction bit
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            port_c_out_o    <= '0;
            port_c_oe_o     <= '0;
            pulse_src_sys_o <= 1'b0;
        end else begin
            port_c_out_o    <= portc_q[PORT_W-1:0];
            port_c_oe_o     <= dir_q;
            pulse_src_sys_o <= portc_q[uppc_pkg::PC_SRC]; // see R2
            if (portc_q[uppc_pkg::PC_EN_A]) begin
                port_c_out_o[uppc_pkg::PC_PWM_A] <= pulse_out_a_i; // see R3
                port_c_oe_o[uppc_pkg::PC_PWM_A]  <= 1'b1; // see R26
            end
            if (portc_q[uppc_pkg::PC_EN_B]) begin
                port_c_out_o[uppc_pkg::PC_PWM_B] <= pulse_out_b_i; // see R4
                port_c_oe_o[uppc_pkg::PC_PWM_B]  <= 1'b1; // see R26
            end
        end
    end

    // Two-stage synchronisers for pins; first stage read only by second
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_a_q  <= '0;
            pin_b_q  <= '0;
            sync_a_q <= 2'b11;
            sync_b_q <= 2'b11;
        end else begin
            pin_a_q  <= port_c_in_i;
            pin_b_q  <= pin_a_q;
            sync_a_q <= {kbd_clock_in_i, kbd_data_in_i};
            sync_b_q <= sync_a_q;
        end
    end

    // ----------------------------------------------------------------
    // Serial link status and control
    // ----------------------------------------------------------------
    // Wake request and PS2 drives are write-only
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            wake_q <= 1'b0; // see R7
            drv_q  <= uppc_pkg::RST_DRV[7:6]; // see R10
        end else if (wsel(uppc_pkg::IDX_STAT)) begin
            wake_q <= wd[uppc_pkg::ST_WAKE]; // see R7
            drv_q  <= {wd[uppc_pkg::ST_CDRV], wd[uppc_pkg::ST_DDRV]}; // see R10
        end
    end

    // Bus reset flag: hardware set wins over a firmware write
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            brst_q <= 1'b0;
        end else if (bus_reset_i) begin
            brst_q <= 1'b1; // see R8
        end else if (wsel(uppc_pkg::IDX_STAT)) begin
            brst_q <= wd[uppc_pkg::ST_BRST]; // see R8
        end
    end

    // Resume-out flag, cleared when firmware reads the status register
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            res_q <= 1'b0;
        end else if (resume_out_i) begin
            res_q <= 1'b1; // see R9
        end else if (valid_ph && !hwrite_i && a_idx == uppc_pkg::IDX_STAT) begin
            res_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Endpoint events and mode
    // ----------------------------------------------------------------
    // Flags: set by access unless already pending; a clear wins over an access to a pending flag
    for (genvar e = 0; e < 2; e++) begin : g_ep
        logic hit;                                    // Access on this endpoint
        assign hit = (e == 0) ? ep0_access_i : ep1_access_i;
        always_ff @(posedge mclk_i or posedge rst_i) begin
            if (rst_i) begin
                ep_q[e] <= 1'b0; // see R11
            end else if (hit && !ep_q[e]) begin
                ep_q[e] <= 1'b1; // see R12, see R13
            end else if (wsel(uppc_pkg::IDX_MODE)) begin
                ep_q[e] <= wd[e] & ep_q[e]; // see R13
            end
        end
    end

    // Interrupt pulse on a fresh endpoint event
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            usb_irq_o <= 1'b0;
        end else begin
            usb_irq_o <= ((ep0_access_i && !ep_q[0]) || (ep1_access_i && !ep_q[1]))
                         && usb_int_en_i && !stack_full_i; // see R12
        end
    end

    // Mode bits; reserved 2,3 stored as zero
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_q <= uppc_pkg::RST_MODE; // see R17
        end else if (wsel(uppc_pkg::IDX_MODE)) begin
            mode_q <= wd & uppc_pkg::MSK_MODE & 8'hf3; // see R14, see R15, see R16, see R18
        end
    end

    // ----------------------------------------------------------------
    // System clock control
    // ----------------------------------------------------------------
    // All bits stored; reserved bits read back as written
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            clk_q <= uppc_pkg::RST_CLK; // see R21
        end else if (wsel(uppc_pkg::IDX_CLK)) begin
            clk_q <= wd; // see R19, see R20, see R22
        end
    end

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------
    // PS2 pin mode only when PS2 selected and USB not
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            kbd_mode_o                   <= 1'b0;
            kbd_data_oe_o                <= 1'b0;
            kbd_clock_oe_o               <= 1'b0;
            remote_wake_request_o        <= 1'b0;
            ep0_busy_o                   <= 1'b0;
            ep1_busy_o                   <= 1'b0;
            converter_reference_select_o <= 1'b1;
            usb_clock_enable_o           <= 1'b0;
            second_suspend_pullup_o      <= 1'b0;
            oscillator_freq_select_o     <= 1'b0;
        end else begin
            kbd_mode_o     <= mode_q[uppc_pkg::MD_PS2] && !mode_q[uppc_pkg::MD_USB]; // see R23
            // Open drain: a drive bit at 0 pulls the line low
            kbd_data_oe_o  <= kbd_mode_o && !drv_q[0]; // see R10, see R23
            kbd_clock_oe_o <= kbd_mode_o && !drv_q[1]; // see R10, see R23
            remote_wake_request_o        <= wake_q; // see R7
            ep0_busy_o                   <= ep_q[0];
            ep1_busy_o                   <= ep_q[1];
            converter_reference_select_o <= mode_q[uppc_pkg::MD_VREF]; // see R17
            usb_clock_enable_o           <= clk_q[uppc_pkg::CK_USBEN]; // see R19
            second_suspend_pullup_o      <= clk_q[uppc_pkg::CK_SUSP2]; // see R20
            oscillator_freq_select_o     <= clk_q[uppc_pkg::CK_FREQ]; // see R21
        end
    end
endmodule : uppc_regs
`default_nettype wire

// >>> test/uppc_props.sv
// Purpose: Port-level assertions for the port control register bank
// Assumes: One clock, asynchronous active-high reset
// Notes:   Bound onto uppc_regs below the module
`timescale 1ns/1ns
`default_nettype none
module uppc_props (
    input wire logic        mclk_i, rst_i, hreadyout_o, hresp_o, kbd_mode_o,
    input wire logic        kbd_data_oe_o, kbd_clock_oe_o, usb_irq_o, ep0_busy_o,
    input wire logic        ep0_access_i, ep1_access_i, usb_int_en_i, stack_full_i,
    input wire logic [31:0] hrdata_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    a_bus_ready: assert property (hreadyout_o) else $error("slave stalled");
    a_resp_okay: assert property (!hresp_o) else $error("error response seen");
    a_upper_zero: assert property (hrdata_o[31:8] == 24'h0) else $error("upper lanes set");
    a_data_pin_mode: assert property (kbd_data_oe_o |-> $past(kbd_mode_o))
        else $error("data pin pulled outside keyboard mode");
    a_clock_pin_mode: assert property (kbd_clock_oe_o |-> $past(kbd_mode_o))
        else $error("clock pin pulled outside keyboard mode");
    a_irq_cause: assert property (usb_irq_o |-> $past(usb_int_en_i && !stack_full_i
        && (ep0_access_i || ep1_access_i))) else $error("interrupt without cause");
    a_irq_fresh: assert property (ep0_access_i && !ep0_busy_o && !$past(ep0_access_i)
        && usb_int_en_i && !stack_full_i |=> usb_irq_o) else $error("interrupt missing");
    a_flag_sets: assert property (ep0_access_i |-> ##[1:2] ep0_busy_o)
        else $error("endpoint flag not set");
    a_full_blocks: assert property ($past(stack_full_i) |-> !usb_irq_o)
        else $error("interrupt while stack full");
    c_irq: cover property (usb_irq_o);
    c_clock_pull: cover property (kbd_clock_oe_o);
    c_busy_hit: cover property (ep0_busy_o && ep0_access_i);
endmodule : uppc_props
bind uppc_regs uppc_props u_props (.mclk_i(mclk_i), .rst_i(rst_i), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .kbd_mode_o(kbd_mode_o), .kbd_data_oe_o(kbd_data_oe_o),
    .kbd_clock_oe_o(kbd_clock_oe_o), .usb_irq_o(usb_irq_o), .ep0_busy_o(ep0_busy_o),
    .ep0_access_i(ep0_access_i), .ep1_access_i(ep1_access_i), .usb_int_en_i(usb_int_en_i),
    .stack_full_i(stack_full_i), .hrdata_o(hrdata_o));
`default_nettype wire

// >>> test/uppc_host_model.sv
// Purpose: Keyboard host on the shared data pins
// Assumes: Open-drain lines with pull-ups
// Notes:   Host pulls low only when the bench tells it to
`timescale 1ns/1ns
`default_nettype none
module uppc_host_model (
    input  wire logic dev_data_oe_i, dev_clock_oe_i, host_data_low_i, host_clock_low_i,
    output logic      data_line_o, clock_line_o
);
    // Wired-AND: pull-up wins unless someone pulls low
    assign data_line_o  = !(dev_data_oe_i || host_data_low_i);
    assign clock_line_o = !(dev_clock_oe_i || host_clock_low_i);
endmodule : uppc_host_model
`default_nettype wire

// >>> test/tb_usb_ps2_port_control_regs.sv
// Purpose: Self-checking bench for the port control register bank
// Assumes: Zero-wait AHB-Lite slave, registers at index times four
// Notes:   Seeded random data mixed with fixed corner values
`timescale 1ns/1ns
`default_nettype none
module tb_usb_ps2_port_control_regs;
    logic mclk_i = 0, rst_i = 1, hsel_i = 0, hwrite_i = 0, suspend_i = 0, usb_int_en_i = 1;
    logic [3:0] ev = 4'h0; // Bus reset, resume-out, endpoint 0, endpoint 1
    logic stack_full_i = 0, pulse_out_a_i = 0, pulse_out_b_i = 0, host_dlow = 0, host_clow = 0;
    logic [1:0] htrans_i = 0;
    logic [31:0] haddr_i = 0, hwdata_i = 0, hrdata_o, rd;
    logic [3:0] port_c_in_i = 0, port_c_out_o, port_c_oe_o;
    logic hreadyout_o, hresp_o, pulse_src_sys_o, usb_irq_o, ep0_busy_o, ep1_busy_o, kbd_mode_o;
    logic remote_wake_request_o, kbd_data_in_i, kbd_clock_in_i, kbd_data_oe_o, kbd_clock_oe_o;
    logic converter_reference_select_o, usb_clock_enable_o, second_suspend_pullup_o;
    logic oscillator_freq_select_o;
    logic [7:0] ix [5] = '{uppc_pkg::IDX_PORTC, uppc_pkg::IDX_PORTC_D, uppc_pkg::IDX_STAT,
                           uppc_pkg::IDX_MODE, uppc_pkg::IDX_CLK};
    int error_cnt = 0, compares = 0, irqs = 0;
    always #5 mclk_i = ~mclk_i;
    always @(posedge mclk_i) if (usb_irq_o === 1'b1) irqs++;
    uppc_regs uut (.mclk_i, .rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i(3'b010),
        .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o, .port_c_in_i,
        .port_c_out_o, .port_c_oe_o, .pulse_out_a_i, .pulse_out_b_i, .pulse_src_sys_o, .suspend_i,
        .bus_reset_i(ev[0]), .resume_out_i(ev[1]), .ep0_access_i(ev[2]), .ep1_access_i(ev[3]),
        .usb_int_en_i, .stack_full_i,
        .usb_irq_o, .ep0_busy_o, .ep1_busy_o, .remote_wake_request_o, .kbd_data_in_i,
        .kbd_clock_in_i, .kbd_data_oe_o, .kbd_clock_oe_o, .kbd_mode_o, .usb_clock_enable_o,
        .converter_reference_select_o, .second_suspend_pullup_o, .oscillator_freq_select_o);
    uppc_host_model host (.dev_data_oe_i(kbd_data_oe_o), .dev_clock_oe_i(kbd_clock_oe_o),
        .host_data_low_i(host_dlow), .host_clock_low_i(host_clow),
        .data_line_o(kbd_data_in_i), .clock_line_o(kbd_clock_in_i));
    // One single word transfer; read data kept in rd
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
        hsel_i <= 1; hwrite_i <= w; htrans_i <= 2'b10; haddr_i <= {22'h0, idx, 2'b00};
        do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
        htrans_i <= 2'b00; hsel_i <= 0; hwdata_i <= {24'h0, d};
        do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
        rd = hrdata_o;
    endtask : bus
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            $display("BAD %s exp %h got %h", nm, e, g);
            error_cnt++;
        end
    endtask : chk
    task automatic pulse(input int k);
        ev[k] <= 1; @(posedge mclk_i); ev[k] <= 0; @(posedge mclk_i);
    endtask : pulse
    function automatic logic [31:0] exp_pc(input logic [7:0] d, input logic [3:0] p);
        return {24'h0, d[7:5], 1'b0, p};
    endfunction : exp_pc
    task automatic conclude;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : conclude
    initial begin
        repeat (5000) @(posedge mclk_i);
        error_cnt++;
        conclude();
    end
    initial begin
        logic [7:0] d;
        void'($urandom(32'h231e));
        repeat (6) @(posedge mclk_i);
        rst_i <= 0;
        @(posedge mclk_i);
        chk("refsel", 1, converter_reference_select_o);
        for (int i = 0; i < 5; i++) begin
            bus(0, ix[i], 0);
            chk("reset", (i == 3) ? 8'h40 : 8'h00, rd & ((i == 2) ? 8'h3d : 8'hff));
        end
        for (int i = 0; i < 5; i++) begin
            d = (i == 0) ? 8'hff : 8'($urandom);
            port_c_in_i <= 4'($urandom); pulse_out_a_i <= d[0]; pulse_out_b_i <= d[1];
            bus(1, ix[0], d); bus(1, ix[1], d); bus(1, ix[4], d); bus(1, ix[3], d & 8'hf0);
            bus(0, ix[0], 0); chk("pc", exp_pc(d, port_c_in_i), rd);
            bus(0, ix[1], 0); chk("dir", d & 8'h0f, rd);
            bus(0, ix[4], 0); chk("clk", d, rd);
            bus(0, ix[3], 0); chk("mode", d & 8'hf0, rd);
            chk("cfg", {d[6], d[4], d[3], d[5], d[6]}, {oscillator_freq_select_o,
                second_suspend_pullup_o, usb_clock_enable_o, pulse_src_sys_o, converter_reference_select_o});
            chk("kmode", d[4] & ~d[5], kbd_mode_o);
            if (d[6]) chk("pwa", {d[0], 1'b1}, {port_c_out_o[2], port_c_oe_o[2]});
            if (d[7]) chk("pwb", {d[1], 1'b1}, {port_c_out_o[3], port_c_oe_o[3]});
        end
        bus(1, ix[3], 8'h40); irqs = 0;
        pulse(2); pulse(2);
        stack_full_i <= 1; pulse(3); stack_full_i <= 0;
        bus(0, ix[3], 0); chk("ep", 8'h43, rd);
        chk("busy", 2'b11, {ep0_busy_o, ep1_busy_o});
        chk("irqs", 1, irqs);
        bus(1, ix[3], 8'h40); bus(0, ix[3], 0); chk("epclr", 8'h40, rd);
        usb_int_en_i <= 0; pulse(3); usb_int_en_i <= 1;
        pulse(0); pulse(1); suspend_i <= 1;
        bus(0, ix[2], 0); chk("st", 8'h0d, rd & 8'h0f);
        chk("irqen", 1, irqs);
        bus(1, ix[2], 8'hc2); bus(0, ix[2], 0); chk("st2", 8'h01, rd & 8'h0f);
        chk("wake", 1, remote_wake_request_o);
        bus(1, ix[3], 8'h50); bus(0, ix[3], 0);
        chk("oe0", 2'b00, {kbd_data_oe_o, kbd_clock_oe_o});
        bus(1, ix[2], 8'h40); host_dlow <= 1; repeat (3) @(posedge mclk_i);
        bus(0, ix[2], 0); chk("ps2a", 4'b0001, {rd[5:4], kbd_data_oe_o, kbd_clock_oe_o});
        host_dlow <= 0; repeat (3) @(posedge mclk_i);
        bus(0, ix[2], 0); chk("ps2b", 2'b01, rd[5:4]);
        bus(1, 8'h18, 8'hff); bus(0, 8'h18, 0); chk("unmapped", 0, rd);
        conclude();
    end
endmodule : tb_usb_ps2_port_control_regs
`default_nettype wire
